// File: spi_ext_checker.sv
`timescale 1ns/1ns
module spi_ext_checker
  import spi_ext_pkg::*;
(
  // Watched ports
  input wire logic    CORE_CLK,
  input wire logic    NRST,
  input wire config_t CONFIG,
  input wire logic    TX0_WR,
  input wire logic    WORD_FLAG_CLR,
  input wire status_t STATUS,
  input wire irq_t    IRQ,
  input wire logic    SCLK_O
);
  logic    up_q;
  status_t s;
  config_t c;
  assign s = STATUS;
  assign c = CONFIG;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // ====
  // Properties
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      up_q <= 1'b0;
    end else begin
      up_q <= 1'b1;
    end
  end
  chk_tx_full: assert property (
    up_q |-> s.tx_full == (s.tx_count == 4'h8)) else $error("tx full");
  chk_tx_empty: assert property (
    up_q |-> s.tx_empty == (s.tx_count == 4'h0)) else $error("tx empty");
  chk_rx_full: assert property (
    up_q |-> s.rx_full == (s.rx_count == 4'h8)) else $error("rx full");
  chk_tx_level: assert property (
    (up_q && $stable(c)) [*2] |-> s.transmit_level_flag ==
    (c.queue_mode && s.tx_count <= {1'b0, c.tx_threshold}))
    else $error("tx level");
  chk_rx_level: assert property (
    (up_q && $stable(c)) [*2] |-> s.receive_level_flag ==
    (c.queue_mode && s.rx_count > {1'b0, c.rx_threshold}))
    else $error("rx level");
  chk_word_irq: assert property (
    $rose(s.word_done_flag) && c.word_done_irq_enable |-> IRQ.word_irq)
    else $error("word irq");
  chk_word_hold: assert property (
    s.word_done_flag && !WORD_FLAG_CLR && !$past(WORD_FLAG_CLR) |=>
    s.word_done_flag) else $error("word flag lost");
  chk_queue_start: assert property (
    TX0_WR && c.queue_mode && !c.slave && !s.busy && !s.rx_full |->
    ##[2:12] $rose(SCLK_O)) else $error("no start");
  cover property (s.tx_full);
  cover property (s.rx_full);
  cover property (s.three_wire_start_flag);
endmodule
bind spi_extended_transfer_modes spi_ext_checker spi_ext_checker_inst (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .CONFIG(CONFIG), .TX0_WR(TX0_WR),
  .WORD_FLAG_CLR(WORD_FLAG_CLR), .STATUS(STATUS), .IRQ(IRQ), .SCLK_O(SCLK_O));

// File: spi_ext_partner.sv
`timescale 1ns/1ns
module spi_ext_partner (
  // Master side lanes
  input  wire logic oe,
  input  wire logic o0,
  input  wire logic o1,
  input  wire logic in0,
  output logic      r0,
  output logic      r1,
  // Slave side link
  output logic       lclk = 1'b0,
  output logic       drv = 1'b0,
  output logic [7:0] got = 8'h00
);
  // ====
  // Echo while the master drives SCLK (oe), inverted otherwise
  assign r0 = oe ? o0 : ~o0;
  assign r1 = oe ? o1 : ~o1;
  // One byte, MSB first, clock only inside it
  task automatic burst(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      drv = d[i];
      #6 lclk = 1'b1;
      got = {got[6:0], in0};
      #6 lclk = 1'b0;
    end
    drv = ~drv;
  endtask
endmodule

// File: spi_ext_pkg.sv
package spi_ext_pkg;

  // ==========================================================================
  // Queue geometry
  localparam int QUEUE_DEPTH = 8;
  localparam int QUEUE_WIDTH = 32;
  localparam int COUNT_W     = 4;

  // ==========================================================================
  // Word, pause and timeout figures
  localparam logic [5:0]  MAX_BITS       = 6'h20;
  localparam logic [5:0]  ONE_CLK        = 6'h01;
  localparam logic [2:0]  BYTE_ALIGN     = 3'h0;
  localparam logic [9:0]  MASTER_TIMEOUT = 10'h040;
  localparam logic [9:0]  SLAVE_TIMEOUT  = 10'h240;
  localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
  localparam logic [3:0]  PINS_IDLE      = 4'hf;

  // ==========================================================================
  // Master shift engine states
  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_SHIFT = 2'b01,
    M_PAUSE = 2'b11
  } mstate_t;

  // ==========================================================================
  // Software configuration and status
  typedef struct packed {
    logic       slave;
    logic       three_wire_enable;
    logic       two_lane_enable;
    logic       dual_io_enable;
    logic       dual_io_dir;
    logic       byte_reorder;
    logic       queue_mode;
    logic [4:0] word_length;
    logic [3:0] pause_length;
    logic [2:0] tx_threshold;
    logic [2:0] rx_threshold;
    logic       word_done_irq_enable;
    logic       three_wire_start_irq_enable;
    logic       tx_level_irq_enable;
    logic       rx_level_irq_enable;
    logic       timeout_irq_enable;
  } config_t;

  typedef struct packed {
    logic               busy;
    logic               word_done_flag;
    logic               three_wire_start_flag;
    logic               timeout_flag;
    logic               tx_full;
    logic               tx_empty;
    logic               rx_full;
    logic               rx_empty;
    logic               transmit_level_flag;
    logic               receive_level_flag;
    logic [COUNT_W-1:0] tx_count;
    logic [COUNT_W-1:0] rx_count;
  } status_t;

  typedef struct packed {
    logic word_irq;
    logic start_irq;
    logic timeout_irq;
    logic tx_level_irq;
    logic rx_level_irq;
  } irq_t;

endpackage

// File: spi_extended_transfer_modes.sv
`timescale 1ns/1ns
module spi_extended_transfer_modes
  import spi_ext_pkg::*;
(
  // Clocks and reset
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  input  wire logic        LINK_SCLK,
  // Configuration
  input  wire config_t     CONFIG,
  // Software strobes
  input  wire logic        GO,
  input  wire logic        TX0_WR,
  input  wire logic [31:0] TX0_DATA,
  input  wire logic        TX1_WR,
  input  wire logic [31:0] TX1_DATA,
  input  wire logic        RX0_RD,
  input  wire logic        SLAVE_TRANSFER_ABORT,
  input  wire logic        WORD_FLAG_CLR,
  input  wire logic        START_FLAG_CLR,
  input  wire logic        TIMEOUT_FLAG_CLR,
  // Software read data and status
  output logic      [31:0] RX0_DATA,
  output logic      [31:0] RX1_DATA,
  output status_t          STATUS,
  output irq_t             IRQ,
  // Serial clock and select
  output logic             SCLK_O,
  output logic             SCLK_OE,
  input  wire logic        SS_N,
  // Data lanes
  input  wire logic        MASTER_OUT_LANE_0_I,
  output logic             MASTER_OUT_LANE_0_O,
  output logic             MASTER_OUT_LANE_0_OE,
  input  wire logic        MASTER_OUT_LANE_1_I,
  output logic             MASTER_OUT_LANE_1_O,
  output logic             MASTER_OUT_LANE_1_OE,
  input  wire logic        MASTER_IN_LANE_0_I,
  output logic             MASTER_IN_LANE_0_O,
  output logic             MASTER_IN_LANE_0_OE,
  input  wire logic        MASTER_IN_LANE_1_I,
  output logic             MASTER_IN_LANE_1_O,
  output logic             MASTER_IN_LANE_1_OE
);

  // ==========================================================================
  // Word geometry
  logic [5:0]  nbits;
  logic [5:0]  clks;
  logic [31:0] mask;
  logic [5:0]  byte_gap_len;
  logic [5:0]  word_gap_len;

  function automatic logic [31:0] align(input logic [31:0] w,
                                        input logic [5:0]  n);
    align = w << (MAX_BITS - n);
  endfunction

  always_comb begin
    nbits = (CONFIG.word_length == 5'h00) ? MAX_BITS
                                          : {1'b0, CONFIG.word_length};
    clks = CONFIG.dual_io_enable ? {1'b0, nbits[5:1]} : nbits;
    mask = (nbits == MAX_BITS) ? 32'hffff_ffff
                               : ((32'h0000_0001 << nbits) - 32'h0000_0001);
    // Four core cycles per serial clock: p + 0.5 periods edge to edge
    byte_gap_len = {CONFIG.pause_length, 2'b00};
    word_gap_len = (byte_gap_len == 6'h00) ? 6'h00
                                           : byte_gap_len - ONE_CLK;
  end

  // ==========================================================================
  // Pin synchronisers: {select, out lane 0, in lane 1, in lane 0}
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      pin_s1_q <= PINS_IDLE;
      pin_s2_q <= PINS_IDLE;
    end else begin
      pin_s1_q <= {SS_N, MASTER_OUT_LANE_0_I, MASTER_IN_LANE_1_I,
                   MASTER_IN_LANE_0_I};
      pin_s2_q <= pin_s1_q;
    end
  end

  // ==========================================================================
  // Queues
  logic               tx_push, tx_pop, tx_full, tx_empty;
  logic               rx_push, rx_pop, rx_full, rx_empty;
  logic [31:0]        tx_head, rx_head, rx_in;
  logic [COUNT_W-1:0] tx_cnt, rx_cnt;

  spi_word_queue #(.WIDTH(QUEUE_WIDTH), .DEPTH(QUEUE_DEPTH), .CW(COUNT_W))
  u_tx_queue (
    .clk       (CORE_CLK),
    .rst_n     (NRST),
    .push      (tx_push),
    .push_data (TX0_DATA),
    .pop       (tx_pop),
    .head      (tx_head),
    .count     (tx_cnt),
    .full      (tx_full),
    .empty     (tx_empty)
  );

  spi_word_queue #(.WIDTH(QUEUE_WIDTH), .DEPTH(QUEUE_DEPTH), .CW(COUNT_W))
  u_rx_queue (
    .clk       (CORE_CLK),
    .rst_n     (NRST),
    .push      (rx_push),
    .push_data (rx_in),
    .pop       (rx_pop),
    .head      (rx_head),
    .count     (rx_cnt),
    .full      (rx_full),
    .empty     (rx_empty)
  );

  // ==========================================================================
  // Master shift engine
  mstate_t     state_q;
  logic        half_q, sclk_q, busy_q;
  logic [5:0]  clk_cnt_q, gap_q, clk_next;
  logic [31:0] tsh0_q, tsh1_q, rsh0_q, rsh1_q;
  logic [31:0] tx0_q, tx1_q, rx_next0, rx_next1;
  logic        m_start, m_fall, m_end, byte_gap, m_pop;

  always_comb begin
    m_start = !CONFIG.slave && (CONFIG.queue_mode
              ? (!tx_empty && !rx_full) : busy_q);
    m_fall   = (state_q == M_SHIFT) && half_q && sclk_q;
    clk_next = clk_cnt_q + ONE_CLK;
    m_end    = m_fall && (clk_next == clks);
    byte_gap = m_fall && !m_end && CONFIG.byte_reorder
               && (clk_next[2:0] == BYTE_ALIGN);
    rx_next0 = CONFIG.dual_io_enable
               ? {rsh0_q[29:0], pin_s2_q[0], pin_s2_q[2]}
               : {rsh0_q[30:0], pin_s2_q[0]};
    rx_next1 = {rsh1_q[30:0], pin_s2_q[1]};
    m_pop    = (state_q == M_IDLE) && m_start && CONFIG.queue_mode;
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state_q   <= M_IDLE;
      half_q    <= 1'b0;
      sclk_q    <= 1'b0;
      clk_cnt_q <= 6'h00;
      gap_q     <= 6'h00;
    end else begin
      case (state_q)
        M_IDLE: begin
          if (m_start) begin
            state_q   <= M_SHIFT;
            half_q    <= 1'b0;
            clk_cnt_q <= 6'h00;
          end
        end
        M_SHIFT: begin
          half_q <= ~half_q;
          if (half_q) begin
            sclk_q <= ~sclk_q;
          end
          if (m_fall) begin
            clk_cnt_q <= m_end ? 6'h00 : clk_next;
          end
          if (m_end) begin
            if (CONFIG.queue_mode && word_gap_len != 6'h00) begin
              state_q <= M_PAUSE;
              gap_q   <= word_gap_len;
            end else begin
              state_q <= M_IDLE;
            end
          end else if (byte_gap && byte_gap_len != 6'h00) begin
            state_q <= M_PAUSE;
            gap_q   <= byte_gap_len;
          end
        end
        M_PAUSE: begin
          gap_q <= gap_q - ONE_CLK;
          if (gap_q == ONE_CLK) begin
            state_q <= (clk_cnt_q == 6'h00) ? M_IDLE : M_SHIFT;
          end
        end
        default: state_q <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      tsh0_q <= WORD_RESET;
      tsh1_q <= WORD_RESET;
      rsh0_q <= WORD_RESET;
      rsh1_q <= WORD_RESET;
    end else if (state_q == M_IDLE && m_start) begin
      tsh0_q <= align(CONFIG.queue_mode ? tx_head : tx0_q, nbits);
      tsh1_q <= align(tx1_q, nbits);
    end else if (m_fall) begin
      tsh0_q <= CONFIG.dual_io_enable ? {tsh0_q[29:0], 2'b00}
                                      : {tsh0_q[30:0], 1'b0};
      tsh1_q <= {tsh1_q[30:0], 1'b0};
      rsh0_q <= rx_next0;
      rsh1_q <= rx_next1;
    end
  end

  // ==========================================================================
  // Slave link domain
  logic        s_act_q, ab_tgl_q, hold_v_q, s_load;
  logic [31:0] s_hold0_q, s_hold1_q;
  logic        l_ab_p_q, l_abort, l_done_tgl_q, l_start_tgl_q;
  logic        l_miso0_q, l_miso1_q;
  logic [5:0]  lcnt_q, l_cnt;
  logic [31:0] ltsh0_q, ltsh1_q, lrsh0_q, lrsh1_q, l_word0_q, l_word1_q;
  logic [31:0] l_src0, l_src1;

  // Link clock stops between words: enable and abort are quasi-static,
  // changed by the core only while the link clock stands still
  always_ff @(posedge LINK_SCLK or negedge NRST) begin
    if (!NRST) begin
      l_ab_p_q <= 1'b0;
    end else begin
      l_ab_p_q <= ab_tgl_q;
    end
  end

  always_comb begin
    l_abort = ab_tgl_q ^ l_ab_p_q;
    l_cnt   = l_abort ? 6'h00 : lcnt_q;
    l_src0  = (l_cnt == 6'h00) ? align(s_hold0_q, nbits) : ltsh0_q;
    l_src1  = (l_cnt == 6'h00) ? align(s_hold1_q, nbits) : ltsh1_q;
  end

  always_ff @(posedge LINK_SCLK or negedge NRST) begin
    if (!NRST) begin
      lcnt_q        <= 6'h00;
      ltsh0_q       <= WORD_RESET;
      ltsh1_q       <= WORD_RESET;
      lrsh0_q       <= WORD_RESET;
      lrsh1_q       <= WORD_RESET;
      l_word0_q     <= WORD_RESET;
      l_word1_q     <= WORD_RESET;
      l_done_tgl_q  <= 1'b0;
      l_start_tgl_q <= 1'b0;
    end else if (!s_act_q) begin
      lcnt_q <= l_cnt;
    end else begin
      ltsh0_q <= {l_src0[30:0], 1'b0};
      ltsh1_q <= {l_src1[30:0], 1'b0};
      lrsh0_q <= {lrsh0_q[30:0], MASTER_OUT_LANE_0_I};
      lrsh1_q <= {lrsh1_q[30:0], MASTER_OUT_LANE_1_I};
      if (l_cnt == 6'h00 && CONFIG.three_wire_enable) begin
        l_start_tgl_q <= ~l_start_tgl_q;
      end
      if (l_cnt + ONE_CLK == nbits) begin
        lcnt_q       <= 6'h00;
        l_word0_q    <= {lrsh0_q[30:0], MASTER_OUT_LANE_0_I};
        l_word1_q    <= {lrsh1_q[30:0], MASTER_OUT_LANE_1_I};
        l_done_tgl_q <= ~l_done_tgl_q;
      end else begin
        lcnt_q <= l_cnt + ONE_CLK;
      end
    end
  end

  // Next bit driven on the falling edge
  always_ff @(negedge LINK_SCLK or negedge NRST) begin
    if (!NRST) begin
      l_miso0_q <= 1'b0;
      l_miso1_q <= 1'b0;
    end else begin
      l_miso0_q <= l_src0[31];
      l_miso1_q <= l_src1[31];
    end
  end

  // ==========================================================================
  // Slave core side: event crossing, transmit hold, abort
  logic [1:0] tg_s1_q, tg_s2_q, tg_p_q;
  logic       s_done, s_start, abort;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      tg_s1_q <= 2'b00;
      tg_s2_q <= 2'b00;
      tg_p_q  <= 2'b00;
    end else begin
      tg_s1_q <= {l_start_tgl_q, l_done_tgl_q};
      tg_s2_q <= tg_s1_q;
      tg_p_q  <= tg_s2_q;
    end
  end

  always_comb begin
    s_done  = tg_s2_q[0] ^ tg_p_q[0];
    s_start = tg_s2_q[1] ^ tg_p_q[1];
    abort   = SLAVE_TRANSFER_ABORT && CONFIG.slave;
    s_load  = CONFIG.slave && CONFIG.queue_mode && !tx_empty
              && (!hold_v_q || s_done);
    tx_push = CONFIG.queue_mode && TX0_WR;
    tx_pop  = m_pop || s_load;
    rx_pop  = CONFIG.queue_mode && RX0_RD;
    rx_push = CONFIG.queue_mode && (m_end || s_done);
    rx_in   = CONFIG.slave ? (l_word0_q & mask) : (rx_next0 & mask);
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s_act_q  <= 1'b0;
      ab_tgl_q <= 1'b0;
    end else begin
      s_act_q  <= CONFIG.slave && busy_q
                  && (CONFIG.three_wire_enable || !pin_s2_q[3]);
      ab_tgl_q <= ab_tgl_q ^ abort;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      hold_v_q  <= 1'b0;
      s_hold0_q <= WORD_RESET;
      s_hold1_q <= WORD_RESET;
    end else begin
      s_hold1_q <= tx1_q;
      if (s_load) begin
        s_hold0_q <= tx_head;
        hold_v_q  <= 1'b1;
      end else begin
        if (s_done) begin
          hold_v_q <= 1'b0;
        end
        if (!CONFIG.queue_mode) begin
          s_hold0_q <= tx0_q;
        end
      end
    end
  end

  // ==========================================================================
  // Data words and busy
  logic [31:0] rx0_q, rx1_q;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      tx0_q <= WORD_RESET;
      tx1_q <= WORD_RESET;
      rx0_q <= WORD_RESET;
      rx1_q <= WORD_RESET;
    end else begin
      if (TX0_WR && !CONFIG.queue_mode) begin
        tx0_q <= TX0_DATA;
      end
      if (TX1_WR) begin
        tx1_q <= TX1_DATA;
      end
      if (m_end) begin
        rx0_q <= rx_next0 & mask;
        rx1_q <= rx_next1 & mask;
      end else if (s_done) begin
        rx0_q <= l_word0_q & mask;
        rx1_q <= l_word1_q & mask;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      busy_q <= 1'b0;
    end else if (CONFIG.queue_mode) begin
      busy_q <= CONFIG.slave
                || (state_q != M_IDLE) || !tx_empty;
    end else if (GO) begin
      busy_q <= 1'b1;
    end else if (m_end || s_done || abort) begin
      busy_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Flags, timeout and registered outputs
  logic       word_flag_q, start_flag_q, to_flag_q, to_hit;
  logic [9:0] to_cnt_q, to_lim;

  always_comb begin
    to_lim = CONFIG.slave ? SLAVE_TIMEOUT : MASTER_TIMEOUT;
    to_hit = CONFIG.queue_mode && !rx_empty && !RX0_RD
             && (to_cnt_q == to_lim);
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      to_cnt_q <= 10'h000;
    end else if (!CONFIG.queue_mode || rx_empty || RX0_RD) begin
      to_cnt_q <= 10'h000;
    end else if (to_cnt_q != to_lim) begin
      to_cnt_q <= to_cnt_q + 10'h001;
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      word_flag_q  <= 1'b0;
      start_flag_q <= 1'b0;
      to_flag_q    <= 1'b0;
    end else begin
      word_flag_q  <= m_end || s_done || abort
                      || (word_flag_q && !WORD_FLAG_CLR);
      start_flag_q <= s_start
                      || (start_flag_q && !START_FLAG_CLR);
      to_flag_q    <= to_hit || (to_flag_q && !TIMEOUT_FLAG_CLR);
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      STATUS   <= '0;
      IRQ      <= '0;
      RX0_DATA <= WORD_RESET;
      RX1_DATA <= WORD_RESET;
    end else begin
      RX0_DATA <= CONFIG.queue_mode ? rx_head : rx0_q;
      RX1_DATA <= rx1_q;
      STATUS.busy                  <= busy_q;
      STATUS.word_done_flag        <= word_flag_q;
      STATUS.three_wire_start_flag <= start_flag_q;
      STATUS.timeout_flag          <= to_flag_q;
      STATUS.tx_full               <= tx_full;
      STATUS.tx_empty              <= tx_empty;
      STATUS.rx_full               <= rx_full;
      STATUS.rx_empty              <= rx_empty;
      STATUS.transmit_level_flag   <= CONFIG.queue_mode
                                      && (tx_cnt <= {1'b0, CONFIG.tx_threshold});
      STATUS.receive_level_flag    <= CONFIG.queue_mode
                                      && (rx_cnt > {1'b0, CONFIG.rx_threshold});
      STATUS.tx_count              <= tx_cnt;
      STATUS.rx_count              <= rx_cnt;
      IRQ.word_irq     <= word_flag_q && CONFIG.word_done_irq_enable;
      IRQ.start_irq    <= start_flag_q
                          && CONFIG.three_wire_start_irq_enable;
      IRQ.timeout_irq  <= to_flag_q && CONFIG.timeout_irq_enable;
      IRQ.tx_level_irq <= STATUS.transmit_level_flag
                          && CONFIG.tx_level_irq_enable;
      IRQ.rx_level_irq <= STATUS.receive_level_flag
                          && CONFIG.rx_level_irq_enable;
    end
  end

  // ==========================================================================
  // Pin drivers
  logic m_miso0_q;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      SCLK_O               <= 1'b0;
      SCLK_OE              <= 1'b0;
      MASTER_OUT_LANE_0_O  <= 1'b0;
      MASTER_OUT_LANE_0_OE <= 1'b0;
      MASTER_OUT_LANE_1_O  <= 1'b0;
      MASTER_OUT_LANE_1_OE <= 1'b0;
      MASTER_IN_LANE_0_OE  <= 1'b0;
      MASTER_IN_LANE_1_OE  <= 1'b0;
      m_miso0_q            <= 1'b0;
    end else begin
      SCLK_O               <= sclk_q;
      SCLK_OE              <= !CONFIG.slave;
      MASTER_OUT_LANE_0_O  <= CONFIG.dual_io_enable ? tsh0_q[30]
                                                    : tsh0_q[31];
      MASTER_OUT_LANE_0_OE <= !CONFIG.slave
                              && !(CONFIG.dual_io_enable && !CONFIG.dual_io_dir);
      MASTER_OUT_LANE_1_O  <= tsh1_q[31];
      MASTER_OUT_LANE_1_OE <= !CONFIG.slave && CONFIG.two_lane_enable;
      m_miso0_q            <= tsh0_q[31];
      MASTER_IN_LANE_0_OE  <= CONFIG.slave ? s_act_q
                              : (CONFIG.dual_io_enable && CONFIG.dual_io_dir);
      MASTER_IN_LANE_1_OE  <= CONFIG.slave && CONFIG.two_lane_enable
                              && s_act_q;
    end
  end

  // Lane 0 in-pin is driven by the master engine only in dual output
  // Slave first bit stands before the first link edge
  assign MASTER_IN_LANE_0_O = !CONFIG.slave ? m_miso0_q
                              : (l_cnt == 6'h00) ? l_src0[31] : l_miso0_q;
  assign MASTER_IN_LANE_1_O = (l_cnt == 6'h00) ? l_src1[31] : l_miso1_q;

endmodule

// File: spi_word_queue.sv
`timescale 1ns/1ns
module spi_word_queue #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int CW    = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  // Drain side
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  // Level
  output logic      [CW-1:0]    count,
  output logic                  full,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [CW-1:0]    cnt_q;
  logic             do_push;
  logic             do_pop;

  always_comb begin
    full    = (cnt_q == CW'(DEPTH));
    empty   = (cnt_q == '0);
    do_push = push && !full;
    do_pop  = pop && !empty;
    head    = mem[rp_q];
    count   = cnt_q;
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp_q] <= push_data;
    end
  end

  // Empty after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule

// File: test_spi_extended_transfer_modes.sv
`timescale 1ns/1ns
module test_spi_extended_transfer_modes;
  import spi_ext_pkg::*;
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin \
  failures++; $display("MISMATCH %0t %s", $time, m); end end
`define WAIT(x) begin int n; n = 0; while (!(x) && n < 3000) begin \
  tick(1); n++; end if (!(x)) begin `CHK(1'b0, 1'b1, "stuck") \
  report_and_stop(); end end
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        go, wr0, rd0, clr, oe, o0, o0e, o1, o1e, i0, i0e, i1, i1e;
  logic        r0, r1, lclk, drv, w_o0, w_o1, w_i0, w_i1, ab;
  logic [31:0] d0, rx0, rx1;
  logic [7:0]  got;
  config_t     cfg;
  status_t     st;
  irq_t        irq;
  int          failures = 0;
  int          num_checks = 0;
  // ====
  // Lane wires and clock
  assign w_o0 = o0e ? o0 : drv;
  assign w_o1 = o1e ? o1 : drv;
  assign w_i0 = i0e ? i0 : r0;
  assign w_i1 = i1e ? i1 : r1;
  always #50 clk = ~clk;
  spi_extended_transfer_modes spi_extended_transfer_modes_inst (
    .CORE_CLK(clk), .NRST(nrst), .LINK_SCLK(lclk), .CONFIG(cfg), .GO(go),
    .TX0_WR(wr0), .TX0_DATA(d0), .TX1_WR(wr0), .TX1_DATA(d0),
    .RX0_RD(rd0), .SLAVE_TRANSFER_ABORT(ab), .WORD_FLAG_CLR(clr),
    .START_FLAG_CLR(clr), .TIMEOUT_FLAG_CLR(clr), .RX0_DATA(rx0),
    .RX1_DATA(rx1), .STATUS(st), .IRQ(irq), .SCLK_O(), .SCLK_OE(oe),
    .SS_N(1'b1), .MASTER_OUT_LANE_0_I(w_o0), .MASTER_OUT_LANE_0_O(o0),
    .MASTER_OUT_LANE_0_OE(o0e), .MASTER_OUT_LANE_1_I(w_o1),
    .MASTER_OUT_LANE_1_O(o1), .MASTER_OUT_LANE_1_OE(o1e),
    .MASTER_IN_LANE_0_I(w_i0), .MASTER_IN_LANE_0_O(i0),
    .MASTER_IN_LANE_0_OE(i0e), .MASTER_IN_LANE_1_I(w_i1),
    .MASTER_IN_LANE_1_O(i1), .MASTER_IN_LANE_1_OE(i1e));
  spi_ext_partner spi_ext_partner_inst (.oe(oe), .o0(w_o0), .o1(w_o1),
    .in0(w_i0), .r0(r0), .r1(r1), .lclk(lclk), .drv(drv), .got(got));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic strobe(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    {ab, go, wr0, rd0, clr} = 5'h00;
    d0 = 32'h0000_0000;
    cfg = '0;
    cfg.queue_mode = 1'b1;
    cfg.word_length = 5'h08;
    cfg.two_lane_enable = 1'b1;
    cfg.word_done_irq_enable = 1'b1;
    cfg.timeout_irq_enable = 1'b1;
    tick(6);
    nrst = 1'b1;
    tick(2);
    `CHK({st.tx_empty, st.rx_empty}, 2'b11, "reset")
    // Ten writes back to back, the last meets a full queue
    wr0 = 1'b1;
    for (int i = 0; i < 10; i++) begin
      d0 = 32'h0000_00a0 + i;
      tick(1);
    end
    wr0 = 1'b0;
    tick(1);
    `CHK({st.tx_full, st.tx_count}, 5'h18, "tx full")
    `WAIT(st.rx_full)
    tick(20);
    `CHK({st.rx_count, st.tx_count}, 8'h81, "halt")
    `CHK(irq.timeout_irq, 1'b1, "timeout")
    for (int i = 0; i < 9; i++) begin
      `WAIT(!st.rx_empty)
      tick(1);
      `CHK(rx0[7:0], 8'(8'ha0 + i), "rx data")
      strobe(rd0);
      tick(3);
    end
    `WAIT(!st.busy && st.tx_empty && st.rx_empty)
    `CHK(st.word_done_flag & irq.word_irq, 1'b1, "done")
    `CHK(rx1[7:0], 8'ha9, "lane 1")
    strobe(clr);
    tick(2);
    `CHK(st.word_done_flag, 1'b0, "clear")
    // Three-wire slave with select held inactive, dual I/O off
    cfg.slave = 1'b1;
    cfg.three_wire_enable = 1'b1;
    cfg.two_lane_enable = 1'b0;
    cfg.queue_mode = 1'b0;
    d0 = 32'h0000_00a5;
    strobe(wr0);
    strobe(go);
    tick(5);
    spi_ext_partner_inst.burst(8'hc6);
    `WAIT(st.word_done_flag)
    tick(2);
    `CHK(rx0[7:0], 8'hc6, "slave rx")
    `CHK(got, 8'ha5, "slave tx")
    `CHK(st.three_wire_start_flag, 1'b1, "start")
    // Abort with no link clock: word flag set, busy dropped
    strobe(clr);
    strobe(go);
    strobe(ab);
    tick(2);
    `CHK({st.word_done_flag, st.busy}, 2'b10, "abort")
    report_and_stop();
  end
endmodule
